// ==== tsg_pkg.sv ====
// tsg_pkg.sv: constants and carrier types for the timer-shared gpio port
//
// Functional notes
// - timer enabled: output-compare channels drive their pins, ahead of plain gpio use
// - during reset every pin is an undriven, high-impedance input
// - latch read gives latch bits where direction is 1, pin levels elsewhere
// - pin-input register always reads pin levels; writes to it do nothing
// - direction bit 0 makes the pin an input, 1 an output, bits 7..0
// - output compare enabled forces the pin to output, stored direction unchanged
// - output compare disabled hands direction control back to the stored bit
// - every pin level always feeds its timer input-capture channel
// - drive bit 0 is full drive, 1 about a sixth; ignored on inputs
// - pull enable 0 off, 1 on; acts only while the pin is an input
// - after reset all pull devices are off, all enable bits cleared
// - polarity picks pull-up or pull-down, applied only when pulled and input
package tsg_pkg;

   // ********************************************************************
   // sizes
   // ********************************************************************
   localparam int TSG_PINS        = 8;
   localparam int TSG_AW          = 3;
   localparam int TSG_SYNC_STAGES = 3;

   // ********************************************************************
   // register offsets
   // ********************************************************************
   localparam logic [TSG_AW-1:0] TSG_OFS_LATCH = 3'h0;
   localparam logic [TSG_AW-1:0] TSG_OFS_PIN   = 3'h1;
   localparam logic [TSG_AW-1:0] TSG_OFS_DIR   = 3'h2;
   localparam logic [TSG_AW-1:0] TSG_OFS_DRIVE = 3'h3;
   localparam logic [TSG_AW-1:0] TSG_OFS_PULL  = 3'h4;
   localparam logic [TSG_AW-1:0] TSG_OFS_POL   = 3'h5;

   // ********************************************************************
   // reset values and read answers
   // ********************************************************************
   localparam logic [TSG_PINS-1:0] TSG_RST_LATCH = 8'h00;
   localparam logic [TSG_PINS-1:0] TSG_RST_DIR   = 8'h00;
   localparam logic [TSG_PINS-1:0] TSG_RST_DRIVE = 8'h00;
   localparam logic [TSG_PINS-1:0] TSG_RST_PULL  = 8'h00;
   localparam logic [TSG_PINS-1:0] TSG_RST_POL   = 8'h00;
   localparam logic [TSG_PINS-1:0] TSG_RD_IDLE   = 8'h00;

   // ********************************************************************
   // field encodings, one bit per pin
   // ********************************************************************
   localparam logic TSG_DIR_IN      = 1'b0;
   localparam logic TSG_DIR_OUT     = 1'b1;
   localparam logic TSG_DRV_FULL    = 1'b0;
   localparam logic TSG_DRV_REDUCED = 1'b1;
   localparam logic TSG_POL_UP      = 1'b0;
   localparam logic TSG_POL_DOWN    = 1'b1;

   // ********************************************************************
   // carrier types
   // ********************************************************************
   typedef struct packed {
      logic [TSG_AW-1:0]   addr;
      logic [TSG_PINS-1:0] wdata;
      logic                wr;
      logic                rd;
   } tsg_bus_req_t;

   typedef struct packed {
      logic                enable;
      logic [TSG_PINS-1:0] oc_en;
      logic [TSG_PINS-1:0] oc_level;
   } tsg_timer_t;

   typedef struct packed {
      logic [TSG_PINS-1:0] out;
      logic [TSG_PINS-1:0] oe;
      logic [TSG_PINS-1:0] reduced;
      logic [TSG_PINS-1:0] pull_en;
      logic [TSG_PINS-1:0] pull_dn;
   } tsg_pad_ctrl_t;

endpackage : tsg_pkg

// ==== tsg_pin_sync.sv ====
// tsg_pin_sync.sv: three-stage pin synchroniser with agreement filter
module tsg_pin_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // raw pins and filtered levels
   input  wire logic [WIDTH-1:0] pin_raw,
   output logic      [WIDTH-1:0] pin_level
);
   import tsg_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] level;
   } tsg_sync_state_t;

   tsg_sync_state_t sync_r;
   tsg_sync_state_t sync_nxt;
   logic [WIDTH-1:0] agree;

   // first stage is read only by the second; the filter looks at stages two and three
   always_comb begin
      sync_nxt       = sync_r;
      agree          = ~(sync_r.s2 ^ sync_r.s3);
      sync_nxt.s1    = pin_raw;
      sync_nxt.s2    = sync_r.s1;
      sync_nxt.s3    = sync_r.s2;
      sync_nxt.level = (agree & sync_r.s2) | (~agree & sync_r.level);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync_r <= '0;
      end else begin
         sync_r <= sync_nxt;
      end
   end

   assign pin_level = sync_r.level;

endmodule : tsg_pin_sync

// ==== tsg_port.sv ====
// tsg_port.sv: eight-pin gpio port shared with the eight-channel timer

// ***********************************************************************
// top level
// ***********************************************************************
module tsg_port (
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst,

   // register port
   input  wire tsg_pkg::tsg_bus_req_t reg_req,
   output logic [tsg_pkg::TSG_PINS-1:0] reg_rdata,

   // eight-channel timer side
   input  wire tsg_pkg::tsg_timer_t   tmr_ctrl,
   output logic [tsg_pkg::TSG_PINS-1:0] tmr_capture_in,

   // shared port pins
   input  wire logic [tsg_pkg::TSG_PINS-1:0] pin_in,
   output tsg_pkg::tsg_pad_ctrl_t     pad_ctrl
);
   import tsg_pkg::*;

   // ********************************************************************
   // state
   // ********************************************************************
   typedef struct packed {
      logic [TSG_PINS-1:0] latch;
      logic [TSG_PINS-1:0] dir;
      logic [TSG_PINS-1:0] drive;
      logic [TSG_PINS-1:0] pull;
      logic [TSG_PINS-1:0] pol;
      logic [TSG_PINS-1:0] rdata;
      tsg_pad_ctrl_t       pad;
   } tsg_state_t;

   // what one pad is doing; every pad control bit except out follows from it
   typedef enum logic [2:0] {
      TSG_ROLE_FLOAT,
      TSG_ROLE_PULL_UP,
      TSG_ROLE_PULL_DOWN,
      TSG_ROLE_DRIVE_FULL,
      TSG_ROLE_DRIVE_REDUCED
   } tsg_pin_role_t;

   // one flag per mapped offset; offsets 6 and 7 leave every flag low
   typedef struct packed {
      logic latch;
      logic pin;
      logic dir;
      logic drive;
      logic pull;
      logic pol;
   } tsg_sel_t;

   // all pads come out of reset undriven with no pull
   localparam tsg_pad_ctrl_t TSG_PAD_RST = '{
      out     : TSG_RST_LATCH,
      oe      : TSG_RST_DIR,
      reduced : TSG_RST_DRIVE,
      pull_en : TSG_RST_PULL,
      pull_dn : TSG_RST_POL
   };

   localparam tsg_state_t TSG_STATE_RST = '{
      latch : TSG_RST_LATCH,
      dir   : TSG_RST_DIR,
      drive : TSG_RST_DRIVE,
      pull  : TSG_RST_PULL,
      pol   : TSG_RST_POL,
      rdata : TSG_RD_IDLE,
      pad   : TSG_PAD_RST
   };

   tsg_state_t          st_r;
   tsg_state_t          st_nxt;
   logic [TSG_PINS-1:0] pin_level;
   logic [TSG_PINS-1:0] oc_force;
   logic [TSG_PINS-1:0] eff_oe;
   tsg_sel_t            wr_sel;
   tsg_sel_t            rd_sel;

   // ********************************************************************
   // helper functions
   // ********************************************************************

   // one-hot register select, shared by the write and the read path
   function automatic tsg_sel_t fn_decode(
      input logic [TSG_AW-1:0] addr
   );
      tsg_sel_t sel;
      sel = '0;
      case (addr)
         TSG_OFS_LATCH: begin
            sel.latch = 1'h1;
         end
         TSG_OFS_PIN: begin
            sel.pin = 1'h1;
         end
         TSG_OFS_DIR: begin
            sel.dir = 1'h1;
         end
         TSG_OFS_DRIVE: begin
            sel.drive = 1'h1;
         end
         TSG_OFS_PULL: begin
            sel.pull = 1'h1;
         end
         TSG_OFS_POL: begin
            sel.pol = 1'h1;
         end
         default: begin
            sel = '0;
         end
      endcase
      fn_decode = sel;
   endfunction : fn_decode

   // per pin, when_one where the sel bit is 1, when_zero elsewhere; used for the latch read and the pad output
   function automatic logic [TSG_PINS-1:0] fn_mix(
      input logic [TSG_PINS-1:0] sel,
      input logic [TSG_PINS-1:0] when_one,
      input logic [TSG_PINS-1:0] when_zero
   );
      fn_mix = (sel & when_one) | (~sel & when_zero);
   endfunction : fn_mix

   // read answer for one address; unmapped offsets read as idle
   function automatic logic [TSG_PINS-1:0] fn_read(
      input tsg_sel_t            sel,
      input tsg_state_t          st,
      input logic [TSG_PINS-1:0] lvl
   );
      logic [TSG_PINS-1:0] val;
      val = TSG_RD_IDLE;
      if (sel.latch) begin
         val = fn_mix(st.dir, st.latch, lvl);
      end
      if (sel.pin) begin
         val = lvl;
      end
      if (sel.dir) begin
         val = st.dir;
      end
      if (sel.drive) begin
         val = st.drive;
      end
      if (sel.pull) begin
         val = st.pull;
      end
      if (sel.pol) begin
         val = st.pol;
      end
      fn_read = val;
   endfunction : fn_read

   // role of one pad from its effective direction and stored setup
   function automatic tsg_pin_role_t fn_role(
      input logic oe,
      input logic drive,
      input logic pull,
      input logic pol
   );
      tsg_pin_role_t role;
      role = TSG_ROLE_FLOAT;
      if (oe == TSG_DIR_OUT) begin
         // drive strength means nothing on an input, so only outputs look at it
         role = TSG_ROLE_DRIVE_FULL;
         if (drive == TSG_DRV_REDUCED) begin
            role = TSG_ROLE_DRIVE_REDUCED;
         end
      end else if (pull) begin
         // polarity only reaches the pad while the pull is really on
         role = TSG_ROLE_PULL_UP;
         if (pol == TSG_POL_DOWN) begin
            role = TSG_ROLE_PULL_DOWN;
         end
      end
      fn_role = role;
   endfunction : fn_role

   // apply one register write; the pin-input offset has no storage behind it
   function automatic tsg_state_t fn_write(
      input tsg_state_t          st,
      input tsg_sel_t            sel,
      input logic [TSG_PINS-1:0] wdata
   );
      tsg_state_t nxt;
      nxt = st;
      if (sel.latch) begin
         nxt.latch = wdata;
      end
      if (sel.pin) begin
         nxt.latch = st.latch;
      end
      if (sel.dir) begin
         nxt.dir = wdata;
      end
      if (sel.drive) begin
         nxt.drive = wdata;
      end
      if (sel.pull) begin
         nxt.pull = wdata;
      end
      if (sel.pol) begin
         nxt.pol = wdata;
      end
      fn_write = nxt;
   endfunction : fn_write

   // pad controls from the stored setup and the effective direction
   function automatic tsg_pad_ctrl_t fn_pad(
      input tsg_state_t          st,
      input logic [TSG_PINS-1:0] oe,
      input logic [TSG_PINS-1:0] force_oc,
      input logic [TSG_PINS-1:0] oc_level
   );
      tsg_pad_ctrl_t pad;
      tsg_pin_role_t role;
      pad     = TSG_PAD_RST;
      role    = TSG_ROLE_FLOAT;
      pad.out = fn_mix(force_oc, oc_level, st.latch);
      for (int i = 0; i < TSG_PINS; i++) begin
         role = fn_role(oe[i], st.drive[i], st.pull[i], st.pol[i]);
         case (role)
            TSG_ROLE_DRIVE_FULL: begin
               pad.oe[i] = 1'h1;
            end
            TSG_ROLE_DRIVE_REDUCED: begin
               pad.oe[i]      = 1'h1;
               pad.reduced[i] = 1'h1;
            end
            TSG_ROLE_PULL_UP: begin
               // pull devices would fight the driver, so outputs never see them
               pad.pull_en[i] = 1'h1;
            end
            TSG_ROLE_PULL_DOWN: begin
               pad.pull_en[i] = 1'h1;
               pad.pull_dn[i] = 1'h1;
            end
            default: begin
               pad.oe[i] = 1'h0;
            end
         endcase
      end
      fn_pad = pad;
   endfunction : fn_pad

   // ********************************************************************
   // pin synchroniser
   // ********************************************************************

   // pins are asynchronous to core_clk; every reader sees the filtered level
   tsg_pin_sync #(
      .WIDTH (TSG_PINS)
   ) u_pin_sync (
      .core_clk  (core_clk),
      .rst       (rst),
      .pin_raw   (pin_in),
      .pin_level (pin_level)
   );

   // ********************************************************************
   // timer override
   // ********************************************************************

   // timer signals come from logic on core_clk and need no synchroniser;
   // a disabled timer releases every pin, whatever its compare setting
   always_comb begin
      oc_force = TSG_RD_IDLE;
      for (int i = 0; i < TSG_PINS; i++) begin
         if (tmr_ctrl.enable && tmr_ctrl.oc_en[i]) begin
            oc_force[i] = 1'h1;
         end
      end
   end

   // the stored direction is never written here, so dropping the
   // override falls straight back to it
   always_comb begin
      eff_oe = st_r.dir;
      for (int i = 0; i < TSG_PINS; i++) begin
         if (oc_force[i]) begin
            eff_oe[i] = TSG_DIR_OUT;
         end
      end
   end

   // ********************************************************************
   // register select
   // ********************************************************************

   // a strobe that is low leaves its select empty
   always_comb begin
      wr_sel = '0;
      rd_sel = '0;
      if (reg_req.wr) begin
         wr_sel = fn_decode(reg_req.addr);
      end
      if (reg_req.rd) begin
         rd_sel = fn_decode(reg_req.addr);
      end
   end

   // ********************************************************************
   // next state
   // ********************************************************************
   always_comb begin
      // register writes; the pin-input offset and offsets 6 and 7 store nothing
      st_nxt = fn_write(st_r, wr_sel, reg_req.wdata);

      // read data stands only in the cycle after the read strobe
      st_nxt.rdata = TSG_RD_IDLE;

      // register reads, taken from the state before any same-edge write
      if (reg_req.rd) begin
         st_nxt.rdata = fn_read(rd_sel, st_r, pin_level);
      end

      // pad controls are registered so the pins never see decode glitches;
      // the cost is one cycle from a setup change to the pad
      st_nxt.pad = fn_pad(st_r, eff_oe, oc_force, tmr_ctrl.oc_level);
   end

   // ********************************************************************
   // state register
   // ********************************************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         // every pin undriven, pulls off, all setup cleared
         st_r <= TSG_STATE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ********************************************************************
   // outputs
   // ********************************************************************
   assign reg_rdata = st_r.rdata;
   assign pad_ctrl  = st_r.pad;

   // capture sees the pin whatever the direction or override
   assign tmr_capture_in = pin_level;

endmodule : tsg_port

// ==== tsg_port_props.sv ====
// tsg_port_props.sv: assertion checker bound to the gpio port
module tsg_port_props (
   // clock and reset
   input wire logic                         core_clk,
   input wire logic                         rst,
   // register port
   input wire tsg_pkg::tsg_bus_req_t        reg_req,
   input wire logic [tsg_pkg::TSG_PINS-1:0] reg_rdata,
   // timer side
   input wire tsg_pkg::tsg_timer_t          tmr_ctrl,
   input wire logic [tsg_pkg::TSG_PINS-1:0] tmr_capture_in,
   // pins
   input wire logic [tsg_pkg::TSG_PINS-1:0] pin_in,
   input wire tsg_pkg::tsg_pad_ctrl_t       pad_ctrl
);
   timeunit 1ns;
   timeprecision 1ns;
   import tsg_pkg::*;
   // ****
   // helpers
   // ****
   logic [TSG_PINS-1:0] oc_r;
   logic [TSG_PINS-1:0] lvl_r;
   logic [TSG_PINS-1:0] pin_r;
   logic [3:0]          calm_r;
   // calm_r counts edges the pins held still, long enough to pass the synchroniser
   always_ff @(posedge core_clk) begin
      if (rst) begin
         oc_r   <= 8'h00;
         lvl_r  <= 8'h00;
         pin_r  <= 8'h00;
         calm_r <= 4'h0;
      end else begin
         oc_r   <= tmr_ctrl.enable ? tmr_ctrl.oc_en : 8'h00;
         lvl_r  <= tmr_ctrl.oc_level;
         pin_r  <= pin_in;
         calm_r <= (pin_in != pin_r) ? 4'h0 : (calm_r == 4'hF) ? calm_r : calm_r + 4'h1;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // ****
   // properties
   // ****
   property p_rst_quiet;
      disable iff (1'b0) rst |=> pad_ctrl == '0 && reg_rdata == 8'h00;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("pads active in reset");
   property p_oc_force; (pad_ctrl.oe & oc_r) == oc_r; endproperty
   a_oc_force: assert property (p_oc_force) else $error("compare pin not driven");
   property p_oc_level; (pad_ctrl.out & oc_r) == (lvl_r & oc_r); endproperty
   a_oc_level: assert property (p_oc_level) else $error("compare level wrong");
   property p_dir;
      reg_req.wr && reg_req.addr == TSG_OFS_DIR && !tmr_ctrl.enable ##1 !tmr_ctrl.enable
         |=> pad_ctrl.oe == $past(reg_req.wdata, 2);
   endproperty
   a_dir: assert property (p_dir) else $error("direction not applied");
   property p_idle; !reg_req.rd |=> reg_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data without read");
   property p_pin_rd;
      reg_req.rd && reg_req.addr == TSG_OFS_PIN |=> reg_rdata == $past(tmr_capture_in);
   endproperty
   a_pin_rd: assert property (p_pin_rd) else $error("pin read differs");
   property p_pull_out; (pad_ctrl.pull_en & pad_ctrl.oe) == 8'h00; endproperty
   a_pull_out: assert property (p_pull_out) else $error("pull on output");
   property p_red_in; (pad_ctrl.reduced & ~pad_ctrl.oe) == 8'h00; endproperty
   a_red_in: assert property (p_red_in) else $error("drive on input");
   property p_pol_gate; (pad_ctrl.pull_dn & ~pad_ctrl.pull_en) == 8'h00; endproperty
   a_pol_gate: assert property (p_pol_gate) else $error("polarity without pull");
   // calm_r only speaks for the pin up to the previous edge, so compare with pin_r
   property p_capture; calm_r >= 4'h7 |-> tmr_capture_in == pin_r; endproperty
   a_capture: assert property (p_capture) else $error("capture lost pin");
   c_rd: cover property (reg_req.rd ##1 reg_rdata != 8'h00);
   c_oc: cover property (oc_r != 8'h00);
   c_dn: cover property (pad_ctrl.pull_dn != 8'h00);
endmodule : tsg_port_props

bind tsg_port tsg_port_props u_props (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .tmr_ctrl(tmr_ctrl), .tmr_capture_in(tmr_capture_in),
   .pin_in(pin_in), .pad_ctrl(pad_ctrl));

// ==== tsg_pin_model.sv ====
// tsg_pin_model.sv: board side of the pins: pad drivers, pulls and an outside source
module tsg_pin_model (
   // clock
   input wire logic                          core_clk,
   // pad controls from the port
   input wire tsg_pkg::tsg_pad_ctrl_t        pad_ctrl,
   // outside source set by the bench
   input wire logic [tsg_pkg::TSG_PINS-1:0]  ext_val,
   input wire logic [tsg_pkg::TSG_PINS-1:0]  ext_en,
   // resolved levels
   output logic [tsg_pkg::TSG_PINS-1:0]      pin
);
   timeunit 1ns;
   timeprecision 1ns;
   import tsg_pkg::*;
   logic [TSG_PINS-1:0] float_r = 8'h00;
   // an undriven pin wanders so no test can lean on a settled default
   always_ff @(posedge core_clk) float_r <= ~float_r;
   always_comb begin
      for (int i = 0; i < TSG_PINS; i++) begin
         if (pad_ctrl.oe[i]) pin[i] = pad_ctrl.out[i];
         else if (ext_en[i]) pin[i] = ext_val[i];
         else if (pad_ctrl.pull_en[i]) pin[i] = ~pad_ctrl.pull_dn[i];
         else pin[i] = float_r[i];
      end
   end
endmodule : tsg_pin_model

// ==== test_timer_shared_gpio_port.sv ====
// test_timer_shared_gpio_port.sv: self-checking bench for the gpio port
module test_timer_shared_gpio_port;
   timeunit 1ns;
   timeprecision 1ns;
   import tsg_pkg::*;
   logic                core_clk;
   logic                rst;
   tsg_bus_req_t        req;
   tsg_timer_t          tmr;
   tsg_pad_ctrl_t       pad;
   logic [TSG_PINS-1:0] rdata, cap, pins, ext_val, ext_en;
   int                  err_total = 0;
   int                  n_checks = 0;
   tsg_port DUT (.core_clk(core_clk), .rst(rst), .reg_req(req), .reg_rdata(rdata),
      .tmr_ctrl(tmr), .tmr_capture_in(cap), .pin_in(pins), .pad_ctrl(pad));
   tsg_pin_model u_pins (.core_clk(core_clk), .pad_ctrl(pad), .ext_val(ext_val),
      .ext_en(ext_en), .pin(pins));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // ****
   // helpers
   // ****
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : idle
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      req.wr <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      req.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rdc
   task automatic complete_run;
      if (err_total == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run
   // ****
   // scenarios
   // ****
   task automatic t_reset;
      chk(pad, 40'h0);
      for (int a = 0; a < 8; a++) rdc(3'(a), (a < 2) ? 8'hA5 : 8'h00);
   endtask : t_reset
   task automatic t_regs;
      wr(TSG_OFS_PIN, 8'hFF);
      wr(3'h6, 8'hFF);
      rdc(TSG_OFS_PIN, 8'hA5);
      for (int a = 2; a < 6; a++) begin
         wr(3'(a), 8'h5A ^ 8'(a));
         rdc(3'(a), 8'h5A ^ 8'(a));
      end
      rdc(3'h7, 8'h00);
   endtask : t_regs
   task automatic t_latch;
      @(posedge core_clk);
      ext_en <= 8'h0F;
      ext_val <= 8'h5A;
      wr(TSG_OFS_DIR, 8'hF0);
      wr(TSG_OFS_LATCH, 8'h3C);
      idle(6);
      chk(pad.oe, 8'hF0);
      chk(cap, 8'h3A);
      rdc(TSG_OFS_LATCH, 8'h3A);
   endtask : t_latch
   task automatic t_pads;
      @(posedge core_clk);
      ext_en <= 8'h00;
      wr(TSG_OFS_DRIVE, 8'hFF);
      wr(TSG_OFS_PULL, 8'hFF);
      wr(TSG_OFS_POL, 8'h0F);
      idle(6);
      chk(pad.reduced, 8'hF0);
      chk(pad.pull_en, 8'h0F);
      chk(pad.pull_dn, 8'h0F);
      rdc(TSG_OFS_PIN, 8'h30);
      wr(TSG_OFS_POL, 8'h00);
      idle(6);
      rdc(TSG_OFS_PIN, 8'h3F);
   endtask : t_pads
   task automatic t_timer;
      wr(TSG_OFS_LATCH, 8'hBC);
      wr(TSG_OFS_PIN, 8'h43);
      @(posedge core_clk);
      tmr <= '{enable: 1'b1, oc_en: 8'h81, oc_level: 8'h00};
      idle(6);
      chk(pad.oe, 8'hF1);
      chk(pad.out & 8'h81, 8'h00);
      chk(pad.pull_en, 8'h0E);
      rdc(TSG_OFS_LATCH, 8'hBE);
      rdc(TSG_OFS_DIR, 8'hF0);
      @(posedge core_clk);
      tmr.enable <= 1'b0;
      idle(6);
      chk(pad.oe, 8'hF0);
      rdc(TSG_OFS_LATCH, 8'hBF);
   endtask : t_timer
   initial begin
      rst = 1'b1;
      req = '0;
      tmr = '0;
      ext_val = 8'hA5;
      ext_en = 8'hFF;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      idle(6);
      t_reset();
      t_regs();
      t_latch();
      t_pads();
      t_timer();
      complete_run();
   end
   initial begin
      #200000;
      err_total++;
      complete_run();
   end
endmodule : test_timer_shared_gpio_port
